/* erp_reset_pin.sv */
// Operation
// RULE_01: Three-cycle low pulse may reset; four always.
// RULE_02: Stay in reset while pin low.
// RULE_03: Leave reset on edge after release.
// RULE_04: Pin reset sets external cause flag.
// RULE_05: Pin drives open-drain low during reset.
// RULE_06: Internal reset sources also drive pin.
// RULE_07: Pin held low until delay elapses.
// RULE_08: Ports A, B, C reset to input.
// RULE_09: Alternate functions disabled on reset.
// RULE_10: Port D bit zero powers up as reset.
// RULE_11: Debugger request resets chip, self-clears.
// RULE_12: Debugger reset sets power-on cause flag.
// RULE_13: Pin passes two flip-flops before use.
// RULE_14: Source holds pin low four cycles.
`timescale 1ns/10ps
`default_nettype none

module erp_reset_pin
    import erp_pkg::*;
#(
    parameter int unsigned DELAY_CYCLES = RESET_DELAY_CYCLES,
    parameter int unsigned FILTER_LEN   = FILTER_CYCLES,
    parameter int unsigned GPIO_WIDTH   = PORT_PINS
) (
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [ADDR_W-1:0]     s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    input  wire logic                  reset_pin_in,
    output logic                       reset_pin_out,
    output logic                       reset_pin_oe,
    input  wire logic                  por_event,
    input  wire logic                  supply_brownout_event,
    input  wire logic                  watchdog_event,
    output logic                       system_reset_n,
    output logic [GPIO_WIDTH-1:0]      gpio_port_dir_input,
    output logic [GPIO_WIDTH-1:0]      gpio_port_alt_enable,
    output logic                       port_d_bit_zero_reset_function,
    output logic                       irq
);

    localparam int unsigned DW = $clog2(DELAY_CYCLES + 1);
    localparam int unsigned FW = $clog2(FILTER_LEN + 1);

    function automatic logic [2:0] reg_sel(input logic [ADDR_W-1:0] a);
        case (a)
            OFS_CAUSE: reg_sel = SEL_CAUSE;
            OFS_MASK:  reg_sel = SEL_MASK;
            OFS_CTRL:  reg_sel = SEL_CTRL;
            OFS_DIR:   reg_sel = SEL_DIR;
            OFS_ALT:   reg_sel = SEL_ALT;
            OFS_STATE: reg_sel = SEL_STATE;
            default:   reg_sel = SEL_NONE;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchroniser.
    logic pin_meta;
    logic pin_sync;
    logic next_pin_meta;
    logic next_pin_sync;

    always_comb begin
        next_pin_meta = reset_pin_in;
        next_pin_sync = pin_meta; // [RULE_13]
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_meta <= 1'b1;
            pin_sync <= 1'b1;
        end else begin
            pin_meta <= next_pin_meta;
            pin_sync <= next_pin_sync;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reset sequencer.
    erp_state_type  state;
    erp_state_type  next_state;
    logic [DW-1:0]  delay_cnt;
    logic [DW-1:0]  next_delay_cnt;
    logic [FW-1:0]  low_cnt;
    logic [FW-1:0]  next_low_cnt;
    erp_ctrl_type   ctrl;
    logic           hw_req;
    logic           internal_req;
    logic           delay_done;
    logic           ext_detect;

    assign hw_req       = por_event | supply_brownout_event | watchdog_event;
    assign internal_req = hw_req | ctrl.debug_reset_request; // [RULE_06] [RULE_11]
    assign delay_done   = delay_cnt == DW'(DELAY_CYCLES - 1);
    // The low count only runs while out of reset, so our own drive during reset is never mistaken.
    assign ext_detect   = (state == ST_RUN) && !pin_sync
                          && (low_cnt == FW'(FILTER_LEN - 1)); // [RULE_01]

    always_comb begin
        next_state     = state;
        next_low_cnt   = '0;
        next_delay_cnt = delay_done ? delay_cnt : delay_cnt + DW'(1);
        case (state)
            ST_RUN: begin
                next_delay_cnt = '0;
                if (!pin_sync) begin
                    next_low_cnt = low_cnt + FW'(1);
                end
                if (internal_req) begin
                    next_state = ST_INT; // [RULE_06] [RULE_11]
                end else if (ext_detect) begin
                    next_state = ST_EXT; // [RULE_01]
                end
            end
            ST_INT: begin
                if (hw_req) begin
                    next_delay_cnt = '0;
                end else if (delay_done) begin
                    next_state = ST_RUN; // [RULE_07]
                end
            end
            ST_EXT: begin
                if (hw_req) begin
                    next_state     = ST_INT;
                    next_delay_cnt = '0;
                end else if (pin_sync && delay_done) begin
                    next_state = ST_RUN; // [RULE_02] [RULE_03]
                end
            end
            default: begin
                next_state     = ST_INT;
                next_delay_cnt = '0;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state     <= ST_INT;
            delay_cnt <= '0;
            low_cnt   <= '0;
        end else begin
            state     <= next_state;
            delay_cnt <= next_delay_cnt;
            low_cnt   <= next_low_cnt;
        end
    end

    assign system_reset_n = (state == ST_RUN);
    // Open-drain: the pin is only ever pulled low, never driven high.
    assign reset_pin_out  = 1'b0;
    assign reset_pin_oe   = (state != ST_RUN) | ctrl.drive_enable; // [RULE_05] [RULE_06] [RULE_07]

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave.
    logic              aw_held;
    logic [ADDR_W-1:0] aw_addr;
    logic              w_held;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              next_aw_held;
    logic [ADDR_W-1:0] next_aw_addr;
    logic              next_w_held;
    logic [31:0]       next_w_data;
    logic [3:0]        next_w_strb;
    logic              next_bvalid;
    logic [1:0]        next_bresp;
    logic              next_rvalid;
    logic [31:0]       next_rdata;
    logic [1:0]        next_rresp;
    logic              wr_go;
    logic [2:0]        wr_sel;
    logic [31:0]       wmask;
    logic [31:0]       rd_word;
    erp_cause_type     cause;
    logic [3:0]        mask;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign wr_go         = aw_held && w_held && !s_axi_bvalid;
    assign wr_sel        = reg_sel(aw_addr);

    for (genvar i = 0; i < 4; i++) begin : g_lane
        assign wmask[8*i +: 8] = {8{w_strb[i]}};
    end

    always_comb begin
        rd_word = 32'h0000_0000;
        case (reg_sel(s_axi_araddr))
            SEL_CAUSE: rd_word[3:0]            = cause;
            SEL_MASK:  rd_word[3:0]            = mask;
            SEL_CTRL:  rd_word[2:0]            = ctrl;
            SEL_DIR:   rd_word[GPIO_WIDTH-1:0] = gpio_port_dir_input;
            SEL_ALT:   rd_word[GPIO_WIDTH-1:0] = gpio_port_alt_enable;
            SEL_STATE: rd_word[1:0]            = {pin_sync, ~system_reset_n};
            default:   rd_word                 = 32'h0000_0000;
        endcase
    end

    always_comb begin
        next_aw_held = aw_held;
        next_aw_addr = aw_addr;
        next_w_held  = w_held;
        next_w_data  = w_data;
        next_w_strb  = w_strb;
        next_bvalid  = s_axi_bvalid;
        next_bresp   = s_axi_bresp;
        next_rvalid  = s_axi_rvalid;
        next_rdata   = s_axi_rdata;
        next_rresp   = s_axi_rresp;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (wr_go) begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rdata  = rd_word;
            next_rresp  = (reg_sel(s_axi_araddr) == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
        end
        if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held      <= 1'b0;
            aw_addr      <= '0;
            w_held       <= 1'b0;
            w_data       <= 32'h0000_0000;
            w_strb       <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OKAY;
        end else begin
            aw_held      <= next_aw_held;
            aw_addr      <= next_aw_addr;
            w_held       <= next_w_held;
            w_data       <= next_w_data;
            w_strb       <= next_w_strb;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp  <= next_bresp;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata  <= next_rdata;
            s_axi_rresp  <= next_rresp;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Cause, mask, control and port configuration registers.
    erp_cause_type   next_cause;
    erp_cause_type   cause_set;
    logic [3:0]      next_mask;
    erp_ctrl_type    next_ctrl;
    logic [GPIO_WIDTH-1:0] next_dir;
    logic [GPIO_WIDTH-1:0] next_alt;
    logic [31:0]     wval;

    always_comb begin
        wval = w_data & wmask;
        cause_set.external = ext_detect && !internal_req; // [RULE_04]
        cause_set.power_on = por_event
                             | ((state == ST_RUN) && ctrl.debug_reset_request); // [RULE_12]
        cause_set.brownout = supply_brownout_event;
        cause_set.watchdog = watchdog_event;
        next_cause = cause;
        next_mask  = mask;
        next_ctrl  = ctrl;
        next_dir   = gpio_port_dir_input;
        next_alt   = gpio_port_alt_enable;
        if (wr_go) begin
            case (wr_sel)
                SEL_CAUSE: next_cause = erp_cause_type'(cause & ~wval[3:0]);
                SEL_MASK:  next_mask  = (mask & ~wmask[3:0]) | wval[3:0];
                SEL_CTRL:  next_ctrl  = erp_ctrl_type'((ctrl & ~wmask[2:0]) | wval[2:0]);
                SEL_DIR:   next_dir   = (next_dir & ~wmask[GPIO_WIDTH-1:0])
                                        | wval[GPIO_WIDTH-1:0];
                SEL_ALT:   next_alt   = (next_alt & ~wmask[GPIO_WIDTH-1:0])
                                        | wval[GPIO_WIDTH-1:0];
                default:   next_mask  = mask;
            endcase
        end
        // A new event in the cycle of a clear write survives the clear.
        next_cause = next_cause | cause_set;
        if (state != ST_RUN) begin
            next_ctrl.debug_reset_request = 1'b0; // [RULE_11]
            next_dir = '1; // [RULE_08]
            next_alt = '0; // [RULE_09]
        end
        if (por_event) begin
            next_ctrl.port_d0_reset_function = 1'b1; // [RULE_10]
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cause                <= erp_cause_type'(CAUSE_RESET);
            mask                 <= MASK_RESET;
            ctrl                 <= erp_ctrl_type'(CTRL_RESET); // [RULE_10]
            gpio_port_dir_input  <= '1; // [RULE_08]
            gpio_port_alt_enable <= '0; // [RULE_09]
        end else begin
            cause                <= next_cause;
            mask                 <= next_mask;
            ctrl                 <= next_ctrl;
            gpio_port_dir_input  <= next_dir;
            gpio_port_alt_enable <= next_alt;
        end
    end

    assign port_d_bit_zero_reset_function = ctrl.port_d0_reset_function;
    assign irq = |(cause & mask);

    ////////////////////////////////////////////////////////////////////////////
    // Assertions.
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_four_low;
        (state == ST_RUN && !pin_sync && !internal_req)[*4];
    endsequence

    sequence s_enter_ext;
        (state == ST_RUN) ##1 (state == ST_EXT);
    endsequence

    property p_filter_four;
        s_four_low |=> (state == ST_EXT);
    endproperty
    a_filter_four: assert property (p_filter_four) // [RULE_01]
        else $error("Four low cycles did not cause a reset.");

    property p_hold_low;
        (state == ST_EXT && !pin_sync && !hw_req) |=> (state == ST_EXT);
    endproperty
    a_hold_low: assert property (p_hold_low) // [RULE_02]
        else $error("Reset left while the pin was still low.");

    property p_release;
        (state == ST_EXT && pin_sync && delay_done && !hw_req) |=> system_reset_n;
    endproperty
    a_release: assert property (p_release) // [RULE_03]
        else $error("Reset not left after pin release.");

    property p_ext_flag;
        s_enter_ext |-> cause.external;
    endproperty
    a_ext_flag: assert property (p_ext_flag) // [RULE_04]
        else $error("External cause flag not set.");

    property p_drive_low;
        !system_reset_n |-> (reset_pin_oe && !reset_pin_out);
    endproperty
    a_drive_low: assert property (p_drive_low) // [RULE_05]
        else $error("Pin not pulled low during reset.");

    property p_internal;
        (state == ST_RUN && hw_req) |=> (state == ST_INT) ##0 reset_pin_oe;
    endproperty
    a_internal: assert property (p_internal) // [RULE_06]
        else $error("Internal event did not drive the pin.");

    property p_delay_hold;
        (state == ST_INT && !delay_done) |=> (state == ST_INT);
    endproperty
    a_delay_hold: assert property (p_delay_hold) // [RULE_07]
        else $error("Pin released before the delay elapsed.");

    property p_port_dir;
        !system_reset_n |=> (&gpio_port_dir_input);
    endproperty
    a_port_dir: assert property (p_port_dir) // [RULE_08]
        else $error("Port pins not inputs after reset.");

    property p_port_alt;
        !system_reset_n |=> (gpio_port_alt_enable == '0);
    endproperty
    a_port_alt: assert property (p_port_alt) // [RULE_09]
        else $error("Alternate functions not disabled after reset.");

    property p_pd0;
        disable iff (1'b0) !aresetn |=> port_d_bit_zero_reset_function;
    endproperty
    a_pd0: assert property (p_pd0) // [RULE_10]
        else $error("Port D bit zero not in reset function at power-up.");

    property p_debug_clear;
        !system_reset_n ##1 !system_reset_n |-> !ctrl.debug_reset_request;
    endproperty
    a_debug_clear: assert property (p_debug_clear) // [RULE_11]
        else $error("Debugger request not cleared during reset.");

    property p_debug_por;
        (state == ST_RUN && ctrl.debug_reset_request) |=> (state == ST_INT) ##0 cause.power_on;
    endproperty
    a_debug_por: assert property (p_debug_por) // [RULE_12]
        else $error("Debugger reset did not set power-on cause.");

endmodule

`default_nettype wire

/* erp_pkg.sv */
`default_nettype none

package erp_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Clock and timing.
    localparam int unsigned CLK_PERIOD_NS      = 8;
    localparam int unsigned RESET_DELAY_NS     = 1000;
    localparam int unsigned RESET_DELAY_CYCLES =
        (RESET_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned FILTER_CYCLES      = 4;
    localparam int unsigned PORT_PINS          = 24;

    ////////////////////////////////////////////////////////////////////////////
    // Register map.
    localparam int unsigned ADDR_W     = 8;
    localparam logic [7:0]  OFS_CAUSE  = 8'h00;
    localparam logic [7:0]  OFS_MASK   = 8'h04;
    localparam logic [7:0]  OFS_CTRL   = 8'h08;
    localparam logic [7:0]  OFS_DIR    = 8'h0C;
    localparam logic [7:0]  OFS_ALT    = 8'h10;
    localparam logic [7:0]  OFS_STATE  = 8'h14;

    localparam logic [2:0]  SEL_CAUSE  = 3'h0;
    localparam logic [2:0]  SEL_MASK   = 3'h1;
    localparam logic [2:0]  SEL_CTRL   = 3'h2;
    localparam logic [2:0]  SEL_DIR    = 3'h3;
    localparam logic [2:0]  SEL_ALT    = 3'h4;
    localparam logic [2:0]  SEL_STATE  = 3'h5;
    localparam logic [2:0]  SEL_NONE   = 3'h7;

    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    ////////////////////////////////////////////////////////////////////////////
    // Field layouts and reset values.
    typedef struct packed {
        logic watchdog;
        logic brownout;
        logic power_on;
        logic external;
    } erp_cause_type;

    typedef struct packed {
        logic port_d0_reset_function;
        logic debug_reset_request;
        logic drive_enable;
    } erp_ctrl_type;

    localparam logic [3:0] CAUSE_RESET = 4'h2;
    localparam logic [3:0] MASK_RESET  = 4'h0;
    localparam logic [2:0] CTRL_RESET  = 3'h4;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_INT,
        ST_EXT
    } erp_state_type;

endpackage

`default_nettype wire

/* erp_reset_pin_end.sv */
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

/* erp_pin_source.sv */
`timescale 1ns/10ps
`default_nettype none

module erp_pin_source (
    input  wire logic       aclk,
    input  wire logic       start,
    input  wire logic [7:0] len,
    input  wire logic       pin_oe,
    input  wire logic       pin_out,
    output logic            pin_level,
    output logic            board_reset_n
);
    logic [7:0] cnt = 8'h00;

    always_ff @(posedge aclk) begin
        if (start) begin
            cnt <= len;
        end else if (cnt != 8'h00) begin
            cnt <= cnt - 8'h01;
        end
    end

    // The pull-up lifts the line the moment this source lets go. The device is fed
    // this level only, since its own pull would otherwise keep it in reset forever.
    assign pin_level     = (cnt == 8'h00);
    assign board_reset_n = pin_level && !(pin_oe && !pin_out);
endmodule

`default_nettype wire

/* tb_top.sv */
`timescale 1ns/10ps
`default_nettype none

module tb_top;
    import erp_pkg::*;
    localparam int DLY = 8;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  awaddr = 8'h00;
    logic [7:0]  araddr = 8'h00;
    logic [7:0]  plen = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic        awvalid = 1'b0;
    logic        wvalid = 1'b0;
    logic        bready = 1'b0;
    logic        arvalid = 1'b0;
    logic        rready = 1'b0;
    logic        por = 1'b0;
    logic        bo = 1'b0;
    logic        wd = 1'b0;
    logic        start = 1'b0;
    logic [3:0]  strb = 4'hf;
    logic        awready, wready, bvalid, arready, rvalid, pin, pout, oe, srst_n, pd0;
    logic        irq, brd;
    logic [1:0]  bresp, rresp, rs;
    logic [31:0] rdata, rd;
    logic [23:0] dir, alt;
    int          fail_count = 0;
    int          samples_checked = 0;
    int          seed = 45783;
    int          bad = 0;
    int          m_cause, m_mask, m_ctrl, m_dir, m_alt;

    always #4 aclk = ~aclk;

    erp_pin_source i_erp_pin_source (.aclk(aclk), .start(start), .len(plen), .pin_oe(oe),
        .pin_out(pout), .pin_level(pin), .board_reset_n(brd));

    erp_reset_pin #(.DELAY_CYCLES(DLY), .FILTER_LEN(FILTER_CYCLES), .GPIO_WIDTH(PORT_PINS))
    i_erp_reset_pin (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .reset_pin_in(pin), .reset_pin_out(pout),
        .reset_pin_oe(oe), .por_event(por), .supply_brownout_event(bo),
        .watchdog_event(wd), .system_reset_n(srst_n), .gpio_port_dir_input(dir),
        .gpio_port_alt_enable(alt), .port_d_bit_zero_reset_function(pd0), .irq(irq));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic hang();
        fail_count++;
        report_and_stop();
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (k = 0; k < 50; k++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        if (k == 50) hang();
        rs = bresp;
        bready <= 1'b0;
    endtask

    task automatic axr(input logic [7:0] a);
        int k;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (k = 0; k < 50; k++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        if (k == 50) hang();
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        axw(a, d);
        chk(rs, RESP_OKAY);
    endtask

    task automatic cmp_all();
        axr(OFS_CAUSE);
        chk(rd, m_cause);
        axr(OFS_MASK);
        chk(rd, m_mask);
        axr(OFS_CTRL);
        chk(rd, m_ctrl);
        axr(OFS_DIR);
        chk(rd, m_dir);
        axr(OFS_ALT);
        chk(rd, m_alt);
        axr(OFS_STATE);
        chk(rd, 32'h0000_0002);
        chk(rs, RESP_OKAY);
        chk(dir, m_dir);
        chk(alt, m_alt);
        chk(pd0, m_ctrl[2]);
        chk(irq, (m_cause & m_mask) != 0);
    endtask

    task automatic scramble();
        m_dir = $random(seed) & 32'h00ff_ffff;
        m_alt = $random(seed) & 32'h00ff_ffff;
        wr(OFS_DIR, m_dir);
        wr(OFS_ALT, m_alt);
    endtask

    // Counts the cycles spent in reset; the pin must be pulled the whole time.
    task automatic run_wait(output int c);
        c = 0;
        do begin
            @(posedge aclk);
            if (srst_n === 1'b0) c++;
            if (srst_n === 1'b0 && (oe !== 1'b1 || brd !== 1'b0)) bad++;
        end while (srst_n !== 1'b1 && c < 300);
        if (c >= 300) hang();
    endtask

    task automatic pulse(input logic [7:0] len);
        @(posedge aclk);
        plen <= len;
        start <= 1'b1;
        @(posedge aclk);
        start <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        int k;
        int c;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        m_cause = 32'h0000_0002;
        m_mask = 32'h0000_0000;
        m_ctrl = 32'h0000_0004;
        m_dir = 32'h00ff_ffff;
        m_alt = 32'h0000_0000;
        run_wait(c);
        cmp_all();
        axr(8'h18);
        chk(rs, RESP_SLVERR);
        chk(rd, 32'h0000_0000);
        axw(8'h18, 32'hffff_ffff);
        chk(rs, RESP_SLVERR);
        // The status word is read-only: the write is answered but has no effect.
        wr(OFS_STATE, 32'h0000_0003);
        wr(OFS_MASK, 32'h0000_000f);
        m_mask = 32'h0000_000f;
        chk(irq, 1'b1);
        wr(OFS_CAUSE, 32'h0000_0002);
        m_cause = 32'h0000_0000;
        wr(OFS_CTRL, 32'h0000_0001);
        m_ctrl = 32'h0000_0001;
        chk({oe, srst_n}, 2'b11);
        wr(OFS_CTRL, 32'h0000_0000);
        m_ctrl = 32'h0000_0000;
        scramble();
        // Only the lowest byte lane is enabled, so the upper bits must survive.
        strb <= 4'h1;
        wr(OFS_DIR, 32'h00ff_ffa5);
        strb <= 4'hf;
        m_dir = (m_dir & 32'h00ff_ff00) | 32'h0000_00a5;
        cmp_all();
        // A three-cycle pulse is filtered out here by choice.
        pulse(8'h03);
        repeat (12) begin
            @(posedge aclk);
            if (srst_n !== 1'b1) bad++;
        end
        chk(bad, 0);
        scramble();
        pulse(8'h04);
        for (k = 0; k < 12 && srst_n !== 1'b0; k++) @(posedge aclk);
        chk(srst_n, 1'b0);
        run_wait(c);
        m_cause = 32'h0000_0001;
        m_dir = 32'h00ff_ffff;
        m_alt = 32'h0000_0000;
        cmp_all();
        pulse(8'h1e);
        for (k = 0; k < 12 && srst_n !== 1'b0; k++) @(posedge aclk);
        for (k = 0; k < 40 && pin === 1'b0; k++) begin
            @(posedge aclk);
            if (srst_n !== 1'b0) bad++;
        end
        run_wait(c);
        chk(c, 2);
        chk(bad, 0);
        for (k = 0; k < 3; k++) begin
            scramble();
            wr(OFS_CTRL, 32'h0000_0000);
            m_ctrl = 32'h0000_0000;
            @(posedge aclk);
            por <= (k == 0);
            bo <= (k == 1);
            wd <= (k == 2);
            @(posedge aclk);
            {por, bo, wd} <= 3'b000;
            run_wait(c);
            chk(c, DLY);
            m_cause = m_cause | (2 << k);
            if (k == 0) m_ctrl = 32'h0000_0004;
            m_dir = 32'h00ff_ffff;
            m_alt = 32'h0000_0000;
            cmp_all();
        end
        chk(bad, 0);
        wr(OFS_MASK, 32'h0000_0000);
        m_mask = 32'h0000_0000;
        wr(OFS_CAUSE, 32'h0000_000f);
        m_cause = 32'h0000_0000;
        scramble();
        wr(OFS_CTRL, 32'h0000_0002);
        run_wait(c);
        m_cause = 32'h0000_0002;
        m_dir = 32'h00ff_ffff;
        m_alt = 32'h0000_0000;
        cmp_all();
        report_and_stop();
    end
endmodule

`default_nettype wire
